// ### rtl/dac_input_mux_frontend.sv
/*
 * Digital front end of a 12-bit multiplexing DAC: input capture, 4:1 or 2:1
 * interleave, segment decode and the final switch register.
 * Assumes clk_sys is the fast sample clock and all inputs are synchronous
 * to it; the data source launches words from the word clock driven here.
 */
`timescale 1ns/1ps
module dac_input_mux_frontend
	import dac_frontend_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	// Mode: high for four channels, low for two
	input  wire logic                muxRatioSelect,
	// Parallel channel words from the data source
	input  wire logic [SAMPLE_W-1:0] chanAWord,
	input  wire logic [SAMPLE_W-1:0] chanBWord,
	input  wire logic [SAMPLE_W-1:0] chanCWord,
	input  wire logic [SAMPLE_W-1:0] chanDWord,
	// Word clock to the data source, differential pair
	output logic                     wordClockOutPos,
	output logic                     wordClockOutNeg,
	// Current switch controls
	output logic [THERM_W-1:0]       thermSwitch,
	output logic [LSB_W-1:0]         binarySwitch
);
	// Divider and select state
	logic [CNT_W-1:0] selCnt_r;
	logic [CNT_W-1:0] selCnt_nxt;
	logic [CNT_W-1:0] lastCnt;
	logic [CNT_W-1:0] highCnt;
	logic             muxSelectHalf;
	logic             muxSelectQuarter;
	logic             captureEn;
	logic             wordClk_nxt;
	logic             wordClkPos_r;
	logic             wordClkNeg_r;

	// Data path
	sample_t          capWord_r [CHAN_N];
	logic [CNT_W-1:0] chanIdx;
	sample_t          muxOut;
	sample_t          muxWord_r;
	therm_t           thermCtl_r;
	lsb_t             binCtl_r;

	seg_path_if segPath ();

	// Divider: wraps at 3 or at 1 depending on the ratio
	assign lastCnt          = muxRatioSelect ? LAST_CNT_FOUR : LAST_CNT_TWO;
	assign highCnt          = muxRatioSelect ? HIGH_CNT_FOUR : HIGH_CNT_TWO;
	assign captureEn        = (selCnt_r == lastCnt);
	// A wrap past the limit after a mode change falls back to zero on its own
	assign selCnt_nxt       = captureEn ? CNT_RST : CNT_W'(selCnt_r + 2'h1);
	assign muxSelectHalf    = selCnt_r[0];
	assign muxSelectQuarter = selCnt_r[1];
	assign wordClk_nxt      = (selCnt_nxt < highCnt);

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			selCnt_r <= CNT_RST;
		else
			selCnt_r <= selCnt_nxt;
	end

	// Word clock rises as channel A (or B) is selected, so the source's
	// falling-edge launch lands mid-word, well away from the capture edge
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wordClkPos_r <= 1'b0;
			wordClkNeg_r <= 1'b1;
		end
		else
		begin
			wordClkPos_r <= wordClk_nxt;
			wordClkNeg_r <= ~wordClk_nxt;
		end
	end

	// Capture every channel on the last cycle of a word period
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int c = 0; c < CHAN_N; c++)
				capWord_r[c] <= SAMPLE_RST;
		end
		else if (captureEn)
		begin
			capWord_r[CHAN_A_IDX] <= chanAWord;
			capWord_r[CHAN_B_IDX] <= chanBWord;
			capWord_r[CHAN_C_IDX] <= chanCWord;
			capWord_r[CHAN_D_IDX] <= chanDWord;
		end
	end

	// Channel choice: both selects in 4:1, half select offset to B in 2:1
	assign chanIdx = muxRatioSelect ? {muxSelectQuarter, muxSelectHalf}
	                                : CNT_W'({1'b0, muxSelectHalf} + CHAN_B_IDX);
	assign muxOut  = capWord_r[chanIdx];

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			muxWord_r <= SAMPLE_RST;
		else
			muxWord_r <= muxOut;
	end

	// Bit 11 of the sample heads the nibble; codes pass unchanged as offset binary
	assign segPath.sample = muxWord_r;

	thermo_decoder i_thermo_decoder
	(
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.seg     (segPath.dec)
	);

	// Last register before the switches keeps all controls edge-aligned
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			thermCtl_r <= THERM_RST;
			binCtl_r   <= LSB_RST;
		end
		else
		begin
			thermCtl_r <= segPath.therm;
			binCtl_r   <= segPath.lsb;
		end
	end

	assign wordClockOutPos = wordClkPos_r;
	assign wordClockOutNeg = wordClkNeg_r;
	assign thermSwitch     = thermCtl_r;
	assign binarySwitch    = binCtl_r;

	// Checks
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	// First pulse after reset is one cycle short; the held-high step skips it
	sequence s_four_mode_word;
		($rose(wordClkPos_r) && muxRatioSelect) ##1 (wordClkPos_r && muxRatioSelect)
		##1 muxRatioSelect [*3];
	endsequence

	sequence s_two_mode_settle;
		!muxRatioSelect [*3];
	endsequence

	a_word_clock_period : assert property (
		s_four_mode_word |-> $rose(wordClkPos_r))
		else $error("word clock period is not four cycles in 4:1 mode");

	a_word_clock_pair : assert property (
		wordClockOutNeg == !wordClockOutPos)
		else $error("word clock pair is not complementary");

	a_capture_at_wrap : assert property (
		(selCnt_r == LAST_CNT_FOUR && muxRatioSelect)
		|=> capWord_r[CHAN_D_IDX] == $past(chanDWord))
		else $error("channel D word not captured at the wrap");

	a_order_four_chan : assert property (
		(selCnt_r == CNT_RST && muxRatioSelect ##1 muxRatioSelect)
		|-> muxWord_r == $past(capWord_r[CHAN_A_IDX])
		##1 muxWord_r == $past(capWord_r[CHAN_B_IDX]))
		else $error("4:1 order A then B broken");

	a_two_chan_alternate : assert property (
		(!muxRatioSelect && !muxSelectHalf)
		|=> muxWord_r == $past(capWord_r[CHAN_B_IDX]))
		else $error("2:1 mode did not present channel B");

	a_quarter_idle_two : assert property (
		s_two_mode_settle |-> !muxSelectQuarter)
		else $error("quarter select active in 2:1 mode");

	a_half_select_toggle : assert property (
		$past(!sys_rst) |-> muxSelectHalf != $past(muxSelectHalf))
		else $error("divide-by-two select did not toggle");

	a_lsb_latency : assert property (
		1'b1 |-> ##2 binCtl_r == $past(muxWord_r[LSB_W-1:0], 2))
		else $error("binary controls misaligned with sample");

	a_therm_level : assert property (
		1'b1 |-> ##2 $countones(thermCtl_r) == $past(muxWord_r[SAMPLE_W-1 -: MSB_W], 2))
		else $error("thermometer level does not match upper nibble");

endmodule : dac_input_mux_frontend

// ### rtl/dac_frontend_pkg.sv
/*
 * Shared widths, divider counts, reset values and types of the DAC
 * input multiplexer front end.
 * Assumes a single fast clock drives the whole front end.
 */
package dac_frontend_pkg;

	// Sample layout: upper nibble segmented, lower byte binary
	localparam int SAMPLE_W = 12;
	localparam int MSB_W    = 4;
	localparam int LSB_W    = 8;
	localparam int THERM_W  = 15;
	localparam int CHAN_N   = 4;
	localparam int CNT_W    = 2;

	// Divider wrap points and word clock high phase per mode
	localparam logic [CNT_W-1:0] CNT_RST       = 2'h0;
	localparam logic [CNT_W-1:0] LAST_CNT_FOUR = 2'h3;
	localparam logic [CNT_W-1:0] LAST_CNT_TWO  = 2'h1;
	localparam logic [CNT_W-1:0] HIGH_CNT_FOUR = 2'h2;
	localparam logic [CNT_W-1:0] HIGH_CNT_TWO  = 2'h1;

	// Channel indices; two-channel mode starts at channel B
	localparam logic [CNT_W-1:0] CHAN_A_IDX    = 2'h0;
	localparam logic [CNT_W-1:0] CHAN_B_IDX    = 2'h1;
	localparam logic [CNT_W-1:0] CHAN_C_IDX    = 2'h2;
	localparam logic [CNT_W-1:0] CHAN_D_IDX    = 2'h3;

	// Reset values: offset binary zero is the minimum output level
	localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 12'h000;
	localparam logic [THERM_W-1:0]  THERM_RST  = 15'h0000;
	localparam logic [LSB_W-1:0]    LSB_RST    = 8'h00;
	localparam logic [MSB_W-1:0]    MSB_RST    = 4'h0;

	typedef logic [SAMPLE_W-1:0] sample_t;
	typedef logic [THERM_W-1:0]  therm_t;
	typedef logic [LSB_W-1:0]    lsb_t;
	typedef logic [MSB_W-1:0]    nibble_t;

endpackage : dac_frontend_pkg

// ### rtl/seg_path_if.sv
/*
 * Carrier between the multiplexer and the segment decoder.
 * Assumes both ends run on the same fast clock.
 */
`timescale 1ns/1ps
interface seg_path_if;
	import dac_frontend_pkg::*;

	sample_t sample;
	therm_t  therm;
	lsb_t    lsb;

	modport src
	(
		output sample,
		input  therm,
		input  lsb
	);

	modport dec
	(
		input  sample,
		output therm,
		output lsb
	);
endinterface : seg_path_if

// ### rtl/thermo_decoder.sv
/*
 * Two-stage thermometer decoder for the upper nibble, with the lower
 * byte delayed by the same one register so both leave aligned.
 * Assumes the sample on the carrier is already registered.
 */
`timescale 1ns/1ps
module thermo_decoder
	import dac_frontend_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	// Sample in, switch controls out
	seg_path_if.dec   seg
);
	// Stage one: coarse and fine comparisons of the two nibble halves
	logic [3:0] hiGe_r;
	logic [3:0] loGe_r;
	lsb_t       lsbDly_r;
	logic [1:0] hiPart;
	logic [1:0] loPart;

	assign hiPart = seg.sample[SAMPLE_W-1 -: 2];
	assign loPart = seg.sample[SAMPLE_W-3 -: 2];

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hiGe_r   <= 4'h1;
			loGe_r   <= 4'h1;
			lsbDly_r <= LSB_RST;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				hiGe_r[i] <= (hiPart >= 2'(i));
				loGe_r[i] <= (loPart >= 2'(i));
			end
			lsbDly_r <= seg.sample[LSB_W-1:0];
		end
	end

	// Stage two: level k = 4r+f is on when hi > r, or hi == r and lo >= f
	genvar k;
	generate
		for (k = 1; k <= THERM_W; k++)
		begin : g_level
			localparam int R = k / 4;
			localparam int F = k % 4;
			if (F == 0)
			begin : g_row
				assign seg.therm[k-1] = hiGe_r[R];
			end
			else if (R == 3)
			begin : g_top
				assign seg.therm[k-1] = hiGe_r[3] & loGe_r[F];
			end
			else
			begin : g_mid
				assign seg.therm[k-1] = hiGe_r[R+1] | (hiGe_r[R] & loGe_r[F]);
			end
		end
	endgenerate

	assign seg.lsb = lsbDly_r;

	// Only a solid run of ones from bit zero is a legal thermometer
	a_therm_shape_solid : assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		((seg.therm + 15'h0001) & seg.therm) == 15'h0000)
		else $error("thermometer code has a gap");

endmodule : thermo_decoder

// ### verification/word_source_model.sv
/*
 * Data source on the far side of the front end: launches one group of
 * channel words per word clock period.
 * Assumes the bench loads the next group before the word clock falls.
 */
`timescale 1ns/1ps
module word_source_model
	import dac_frontend_pkg::*;
(
	// Clocks seen by the source
	input  wire logic clk_sys,
	input  wire logic wordClockOutPos,
	// Channel words, bit 11 most significant
	output sample_t   chanAWord,
	output sample_t   chanBWord,
	output sample_t   chanCWord,
	output sample_t   chanDWord
);
	sample_t nextWord [CHAN_N];

	initial
	begin
		chanAWord = SAMPLE_RST;
		chanBWord = SAMPLE_RST;
		chanCWord = SAMPLE_RST;
		chanDWord = SAMPLE_RST;
		foreach (nextWord[i]) nextWord[i] = SAMPLE_RST;
	end

	task automatic load(input sample_t a, input sample_t b, input sample_t c, input sample_t d);
		nextWord[0] = a;
		nextWord[1] = b;
		nextWord[2] = c;
		nextWord[3] = d;
	endtask : load

	// Launch after the falling word clock, well clear of the capture edge
	always @(negedge wordClockOutPos)
	begin
		@(negedge clk_sys);
		chanAWord = nextWord[0];
		chanBWord = nextWord[1];
		chanCWord = nextWord[2];
		chanDWord = nextWord[3];
	end
endmodule : word_source_model

// ### verification/dac_input_mux_frontend_tb.sv
/*
 * Self-checking bench for the DAC input multiplexer front end.
 * Assumes a 25 MHz clk_sys and the word source model as data supplier.
 */
`timescale 1ns/1ps
module dac_input_mux_frontend_tb;
	import dac_frontend_pkg::*;

	logic    clk_sys;
	logic    sys_rst;
	logic    muxRatioSelect;
	sample_t chanAWord;
	sample_t chanBWord;
	sample_t chanCWord;
	sample_t chanDWord;
	logic    wordClockOutPos;
	logic    wordClockOutNeg;
	therm_t  thermSwitch;
	lsb_t    binarySwitch;
	int      errTotal;
	int      checks;

	dac_input_mux_frontend i_dac_input_mux_frontend
	(
		.clk_sys(clk_sys), .sys_rst(sys_rst), .muxRatioSelect(muxRatioSelect),
		.chanAWord(chanAWord), .chanBWord(chanBWord), .chanCWord(chanCWord),
		.chanDWord(chanDWord), .wordClockOutPos(wordClockOutPos),
		.wordClockOutNeg(wordClockOutNeg), .thermSwitch(thermSwitch),
		.binarySwitch(binarySwitch)
	);

	word_source_model i_word_source_model
	(
		.clk_sys(clk_sys), .wordClockOutPos(wordClockOutPos),
		.chanAWord(chanAWord), .chanBWord(chanBWord), .chanCWord(chanCWord),
		.chanDWord(chanDWord)
	);

	initial clk_sys = 1'b0;
	always #20 clk_sys = ~clk_sys;

	task automatic endOfTest;
		if (errTotal == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : endOfTest

	task automatic cmpSw(input sample_t w);
		therm_t expTherm;
		expTherm = therm_t'((16'h0001 << w[11:8]) - 16'h0001);
		checks++;
		if (thermSwitch !== expTherm || binarySwitch !== w[7:0])
		begin
			errTotal++;
			$display("[ERR] %0t switches %h/%h for word %h", $time, thermSwitch, binarySwitch, w);
		end
	endtask : cmpSw

	task automatic cmpBit(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp)
		begin
			errTotal++;
			$display("[ERR] %0t %s is %b", $time, what, got);
		end
	endtask : cmpBit

	// Holds reset 4 cycles; outputs must sit at minimum code throughout
	task automatic scnReset;
		sys_rst = 1'b1;
		repeat (4)
		begin
			@(negedge clk_sys);
			cmpBit(wordClockOutPos, 1'b0, "word clock in reset");
			cmpBit(wordClockOutNeg, 1'b1, "inverse word clock in reset");
			cmpSw(SAMPLE_RST);
		end
		sys_rst = 1'b0;
	endtask : scnReset

	// Word clock shape over two periods of four or four of two cycles
	task automatic scnClock(input bit four);
		logic expPos;
		// In four-channel mode the first pulse after reset is short, so judge from the next full period
		@(negedge wordClockOutPos);
		@(posedge wordClockOutPos);
		for (int i = 0; i < 8; i++)
		begin
			@(negedge clk_sys);
			expPos = four ? (i % 4 < 2) : (i % 2 == 0);
			cmpBit(wordClockOutPos, expPos, "word clock");
			cmpBit(wordClockOutNeg, ~expPos, "inverse word clock");
		end
	endtask : scnClock

	// One group through the pipe; the wrap shows the next period's first word
	task automatic scnGroup(input sample_t a, input sample_t b, input sample_t c,
		input sample_t d, input bit four);
		sample_t expWord [CHAN_N];
		int      first;
		int      last;
		expWord = '{a, b, c, d};
		first = four ? 0 : 1;
		last = four ? 3 : 2;
		i_word_source_model.load(a, b, c, d);
		@(negedge wordClockOutPos);
		@(posedge wordClockOutPos);
		repeat (3) @(posedge clk_sys);
		for (int i = first; i <= last; i++)
		begin
			@(negedge clk_sys);
			cmpSw(expWord[i]);
		end
		@(negedge clk_sys);
		cmpSw(expWord[first]);
	endtask : scnGroup

	// Every nibble value, 000 and FFF included, in four-channel order
	task automatic scnAllCodes;
		sample_t w [CHAN_N];
		nibble_t n;
		for (int k = 0; k < 4; k++)
		begin
			for (int j = 0; j < 4; j++)
			begin
				n = nibble_t'(4 * k + j);
				w[j] = {n, lsb_t'(n) * 8'h11};
			end
			scnGroup(w[0], w[1], w[2], w[3], 1'b1);
		end
	endtask : scnAllCodes

	initial
	begin
		errTotal = 0;
		checks = 0;
		sys_rst = 1'b1;
		muxRatioSelect = 1'b1;
		scnReset();
		scnClock(1'b1);
		scnGroup(12'h1A5, 12'h7C3, 12'hB3C, 12'hE5A, 1'b1);
		scnAllCodes();
		// Mode is static, so switch it only under reset
		muxRatioSelect = 1'b0;
		scnReset();
		scnClock(1'b0);
		scnGroup(12'hF0F, 12'h3C3, 12'hC3C, 12'h0F0, 1'b0);
		scnGroup(12'h000, 12'hFFF, 12'h000, 12'hFFF, 1'b0);
		scnReset();
		endOfTest();
	end

	// Whole run is about 110 cycles; 4000 means a hang
	initial
	begin
		#160000;
		errTotal++;
		endOfTest();
	end
endmodule : dac_input_mux_frontend_tb
